// ---- hw/acqs_pkg.sv ----
package acqs_pkg;
  // Register byte offsets
  localparam logic [7:0] ACQS_OFF_CMD = 8'h00;
  localparam logic [7:0] ACQS_OFF_LATCH = 8'h04;
  localparam logic [7:0] ACQS_OFF_STATUS = 8'h08;
  localparam logic [7:0] ACQS_OFF_JMP_HI = 8'h0C;
  localparam logic [7:0] ACQS_OFF_JMP_LO = 8'h10;
  localparam logic [7:0] ACQS_OFF_CONFIG = 8'h14;
  localparam logic [7:0] ACQS_OFF_RESP = 8'h18;

  // Command word fields
  localparam int ACQS_CMD_FN_LSB = 0;
  localparam int ACQS_CMD_WD_LSB = 8;

  // Latch fields
  localparam int ACQS_LAT_NOC_LSB = 0;
  localparam int ACQS_LAT_CLK_LSB = 2;
  localparam int ACQS_LAT_PTL_LSB = 5;
  localparam logic [7:0] ACQS_LATCH_RST = 8'h00;

  // Jumper source codes
  localparam logic [2:0] ACQS_JMP_ZERO = 3'h0;
  localparam logic [2:0] ACQS_JMP_ONE = 3'h1;
  localparam logic [2:0] ACQS_JMP_L0 = 3'h2;
  localparam logic [2:0] ACQS_JMP_L1 = 3'h3;
  localparam logic [2:0] ACQS_JMP_L2 = 3'h4;
  localparam logic [26:0] ACQS_JMP_HI_RST = 27'h0000000;
  localparam logic [5:0] ACQS_JMP_LO_RST = 6'h00;
  localparam logic [1:0] ACQS_MODCNT_RST = 2'h1;

  // Function codes
  localparam logic [4:0] ACQS_F_READ_LATCH = 5'h03;
  localparam logic [4:0] ACQS_F_TEST_LAM = 5'h08;
  localparam logic [4:0] ACQS_F_RESET = 5'h09;
  localparam logic [4:0] ACQS_F_CLEAR_LAM = 5'h0A;
  localparam logic [4:0] ACQS_F_CONTINUOUS = 5'h0B;
  localparam logic [4:0] ACQS_F_SET_LATCH = 5'h11;
  localparam logic [4:0] ACQS_F_SINGLE = 5'h13;
  localparam logic [4:0] ACQS_F_LAM_OFF = 5'h18;
  localparam logic [4:0] ACQS_F_STOP = 5'h19;
  localparam logic [4:0] ACQS_F_LAM_ON = 5'h1A;
  localparam logic [4:0] ACQS_F_BUS_CLOCK = 5'h1B;

  // Timing
  localparam int ACQS_CLK_HZ = 50000000;
  localparam int ACQS_SCAN_NS_PER_CH = 5500;
  localparam int ACQS_SCAN_CYC_PER_CH = ACQS_SCAN_NS_PER_CH / (1000000000 / ACQS_CLK_HZ);
  localparam int ACQS_RATE_1_HZ = 200;
  localparam int ACQS_RATE_2_HZ = 1000;
  localparam int ACQS_RATE_3_HZ = 2000;
  localparam int ACQS_RATE_4_HZ = 5000;
  localparam int ACQS_RATE_5_HZ = 10000;
  localparam int ACQS_RATE_6_HZ = 20000;
  localparam int ACQS_RATE_7_HZ = 40000;
  localparam int ACQS_DIV_6 = ACQS_CLK_HZ / ACQS_RATE_6_HZ;
  localparam int ACQS_DIV_7 = ACQS_CLK_HZ / ACQS_RATE_7_HZ;
  localparam logic [15:0] ACQS_HALF_MODULE = 16'h4000;

  typedef enum logic [1:0] {
    ACQS_SCAN_IDLE,
    ACQS_SCAN_ARMED,
    ACQS_SCAN_WAIT
  } acqs_scan_t;
endpackage

// ---- hw/acqs_sequencer.sv ----
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
module acqs_sequencer #(
  parameter int DIV_1 = 250000,
  parameter int DIV_2 = 50000,
  parameter int DIV_3 = 25000,
  parameter int DIV_4 = 10000,
  parameter int DIV_5 = 5000
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic dataway_clear,
  input wire logic dataway_init,
  input wire logic stop_trigger_in,
  input wire logic external_sample_input,
  output logic sample_strobe,
  output logic channel_counter_reset,
  output logic readout_mode,
  output logic data_valid,
  output logic lam_line,
  output logic [2:0] post_trigger_latch_bits
);
  // Pin synchronisers
  logic [1:0] clr_sync_r, init_sync_r, stop_sync_r, ext_sync_r;
  logic ext_prev_r;
  // Bus data phase
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  // Software state
  logic [7:0] latch_r;
  logic [26:0] jmp_hi_r;
  logic [5:0] jmp_lo_r;
  logic [1:0] modcnt_r;
  logic [7:0] resp_data_r;
  logic resp_x_r, resp_q_r;
  // Sequencer state
  logic sample_en_r, counting_r, readout_r, valid_r, lam_pend_r, lam_en_r;
  logic [15:0] pt_count_r;
  logic [17:0] div_r;
  logic [13:0] scan_timer_r;
  acqs_pkg::acqs_scan_t scan_r, scan_nxt;
  // Output flops
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic sample_strobe_r, chan_rst_r, lam_line_r;

  function automatic logic src_bit(input logic [2:0] sel, input logic [2:0] lat);
    logic b;
    b = 1'b0;
    case (sel)
      acqs_pkg::ACQS_JMP_ONE: b = 1'b1;
      acqs_pkg::ACQS_JMP_L0: b = lat[0];
      acqs_pkg::ACQS_JMP_L1: b = lat[1];
      acqs_pkg::ACQS_JMP_L2: b = lat[2];
      default: b = 1'b0;
    endcase
    return b;
  endfunction

  function automatic logic [17:0] rate_div(input logic [2:0] sel);
    logic [17:0] d;
    d = 18'h00000;
    case (sel)
      3'h1: d = 18'(DIV_1);
      3'h2: d = 18'(DIV_2);
      3'h3: d = 18'(DIV_3);
      3'h4: d = 18'(DIV_4);
      3'h5: d = 18'(DIV_5);
      3'h6: d = 18'(acqs_pkg::ACQS_DIV_6);
      3'h7: d = 18'(acqs_pkg::ACQS_DIV_7);
      default: d = 18'h00000;
    endcase
    return d;
  endfunction

  // Bus decode
  wire addr_phase = hsel && htrans[1] && hready;
  wire [7:0] addr_lo = haddr[7:0];
  wire cmd_wr = wr_pend_r && (wr_addr_r == acqs_pkg::ACQS_OFF_CMD);
  wire [4:0] fn = hwdata[acqs_pkg::ACQS_CMD_FN_LSB +: 5];
  wire [7:0] fn_wdata = hwdata[acqs_pkg::ACQS_CMD_WD_LSB +: 8];
  wire f_read_latch = cmd_wr && (fn == acqs_pkg::ACQS_F_READ_LATCH);
  wire f_test_lam = cmd_wr && (fn == acqs_pkg::ACQS_F_TEST_LAM);
  wire f_reset = cmd_wr && (fn == acqs_pkg::ACQS_F_RESET);
  wire f_clear_lam = cmd_wr && (fn == acqs_pkg::ACQS_F_CLEAR_LAM);
  wire f_cont = cmd_wr && (fn == acqs_pkg::ACQS_F_CONTINUOUS);
  wire f_set_latch = cmd_wr && (fn == acqs_pkg::ACQS_F_SET_LATCH);
  wire f_single = cmd_wr && (fn == acqs_pkg::ACQS_F_SINGLE);
  wire f_lam_off = cmd_wr && (fn == acqs_pkg::ACQS_F_LAM_OFF);
  wire f_stop = cmd_wr && (fn == acqs_pkg::ACQS_F_STOP);
  wire f_lam_on = cmd_wr && (fn == acqs_pkg::ACQS_F_LAM_ON);
  wire f_bus_clk = cmd_wr && (fn == acqs_pkg::ACQS_F_BUS_CLOCK);
  wire f_known = f_read_latch || f_test_lam || f_reset || f_clear_lam || f_cont
    || f_set_latch || f_single || f_lam_off || f_stop || f_lam_on || f_bus_clk;

  // Combined reset request
  wire seq_reset = f_reset || clr_sync_r[1] || init_sync_r[1];

  // Latch fields
  wire [1:0] noc_code = latch_r[acqs_pkg::ACQS_LAT_NOC_LSB +: 2];
  wire [2:0] clk_sel = latch_r[acqs_pkg::ACQS_LAT_CLK_LSB +: 3];
  wire [2:0] ptl = latch_r[acqs_pkg::ACQS_LAT_PTL_LSB +: 3];

  // Jumper plug: nine single bits, then the two shared groups
  logic [15:0] preset;
  always_comb begin
    preset = 16'h0000;
    for (int i = 0; i < 9; i++) begin
      preset[15 - i] = src_bit(jmp_hi_r[3 * i +: 3], ptl);
    end
    preset[6:4] = {3{src_bit(jmp_lo_r[5:3], ptl)}};
    preset[3:0] = {4{src_bit(jmp_lo_r[2:0], ptl)}};
  end

  // Wraps to zero for four modules, as a 16-bit counter does
  wire [15:0] terminal = 16'(acqs_pkg::ACQS_HALF_MODULE * {14'h0000, modcnt_r});
  wire at_terminal = (pt_count_r == terminal);
  wire run_out = readout_r;

  // Sample clock sources
  wire ext_selected = (clk_sel == 3'h0);
  wire int_tick = !ext_selected && (div_r == 18'h00001);
  wire ext_edge = ext_selected && ext_sync_r[1] && !ext_prev_r;
  wire bus_tick = f_bus_clk && ext_selected && !ext_sync_r[1];
  wire raw_sample = int_tick || ext_edge || bus_tick;
  wire gated_sample = raw_sample && sample_en_r && !run_out && !seq_reset;

  // Stop trigger, ignored once started
  wire stop_evt = (stop_sync_r[1] || f_stop) && !counting_r && !readout_r;

  // Channel count in channels: 4 << code
  wire [5:0] nchan = 6'(6'h04 << noc_code);
  wire [13:0] scan_wait = 14'(acqs_pkg::ACQS_SCAN_CYC_PER_CH * {26'h0000000, nchan});

  wire scan_done = (scan_r == acqs_pkg::ACQS_SCAN_WAIT) && (scan_timer_r == 14'h0001);
  wire count_done = counting_r && gated_sample && (16'(pt_count_r + 16'h0001) == terminal);
  wire idle_term = !counting_r && !readout_r && at_terminal && !seq_reset;
  wire enter_readout = count_done || idle_term;

  // Single-scan sequence
  always_comb begin
    scan_nxt = scan_r;
    unique case (scan_r)
      acqs_pkg::ACQS_SCAN_IDLE: begin
        if (f_single && !run_out) begin
          scan_nxt = acqs_pkg::ACQS_SCAN_ARMED;
        end
      end
      acqs_pkg::ACQS_SCAN_ARMED: begin
        if (gated_sample) begin
          scan_nxt = acqs_pkg::ACQS_SCAN_WAIT;
        end else if (f_cont) begin
          scan_nxt = acqs_pkg::ACQS_SCAN_IDLE;
        end
      end
      acqs_pkg::ACQS_SCAN_WAIT: begin
        if (scan_done) begin
          scan_nxt = acqs_pkg::ACQS_SCAN_IDLE;
        end
      end
    endcase
    if (seq_reset) begin
      scan_nxt = acqs_pkg::ACQS_SCAN_IDLE;
    end
  end

  // Sample enable next value
  logic sample_en_nxt;
  always_comb begin
    sample_en_nxt = sample_en_r;
    if (seq_reset) begin
      sample_en_nxt = 1'b1;
    end else if (enter_readout) begin
      sample_en_nxt = 1'b0;
    end else if ((scan_r == acqs_pkg::ACQS_SCAN_ARMED) && gated_sample) begin
      sample_en_nxt = 1'b0;
    end else if ((f_cont || f_single) && !run_out) begin
      sample_en_nxt = 1'b1;
    end
  end

  // Register read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    case (addr_lo)
      acqs_pkg::ACQS_OFF_LATCH: rd_mux = {24'h000000, latch_r};
      acqs_pkg::ACQS_OFF_STATUS: rd_mux = {pt_count_r, 8'h00, scan_r, valid_r,
        counting_r, readout_r, sample_en_r, lam_en_r, lam_pend_r};
      acqs_pkg::ACQS_OFF_JMP_HI: rd_mux = {5'h00, jmp_hi_r};
      acqs_pkg::ACQS_OFF_JMP_LO: rd_mux = {26'h0000000, jmp_lo_r};
      acqs_pkg::ACQS_OFF_CONFIG: rd_mux = {30'h00000000, modcnt_r};
      acqs_pkg::ACQS_OFF_RESP: rd_mux = {22'h000000, resp_q_r, resp_x_r, resp_data_r};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Synchronisers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      clr_sync_r <= 2'h0;
      init_sync_r <= 2'h0;
      stop_sync_r <= 2'h0;
      ext_sync_r <= 2'h0;
      ext_prev_r <= 1'b0;
    end else begin
      clr_sync_r <= {clr_sync_r[0], dataway_clear};
      init_sync_r <= {init_sync_r[0], dataway_init};
      stop_sync_r <= {stop_sync_r[0], stop_trigger_in};
      ext_sync_r <= {ext_sync_r[0], external_sample_input};
      ext_prev_r <= ext_sync_r[1];
    end
  end

  // AHB-Lite slave, zero wait states
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h00000000;
      hreadyout_r <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      wr_pend_r <= addr_phase && hwrite;
      wr_addr_r <= addr_lo;
      if (addr_phase && !hwrite) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  // Software registers; jumpers and latch survive a sequencer reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      latch_r <= acqs_pkg::ACQS_LATCH_RST;
      jmp_hi_r <= acqs_pkg::ACQS_JMP_HI_RST;
      jmp_lo_r <= acqs_pkg::ACQS_JMP_LO_RST;
      modcnt_r <= acqs_pkg::ACQS_MODCNT_RST;
    end else begin
      if (f_set_latch) begin
        latch_r <= fn_wdata;
      end else if (wr_pend_r && (wr_addr_r == acqs_pkg::ACQS_OFF_LATCH)) begin
        latch_r <= hwdata[7:0];
      end
      if (wr_pend_r && (wr_addr_r == acqs_pkg::ACQS_OFF_JMP_HI)) begin
        jmp_hi_r <= hwdata[26:0];
      end
      if (wr_pend_r && (wr_addr_r == acqs_pkg::ACQS_OFF_JMP_LO)) begin
        jmp_lo_r <= hwdata[5:0];
      end
      if (wr_pend_r && (wr_addr_r == acqs_pkg::ACQS_OFF_CONFIG)) begin
        modcnt_r <= hwdata[1:0];
      end
    end
  end

  // Command response
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      resp_data_r <= 8'h00;
      resp_x_r <= 1'b0;
      resp_q_r <= 1'b0;
    end else if (cmd_wr) begin
      resp_x_r <= f_known;
      resp_q_r <= f_test_lam && lam_pend_r;
      resp_data_r <= f_read_latch ? latch_r : 8'h00;
    end
  end

  // Request flags; a new event beats a clear in the same cycle
  wire lam_set = scan_done || enter_readout;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lam_pend_r <= 1'b0;
      lam_en_r <= 1'b0;
      lam_line_r <= 1'b0;
    end else begin
      if (lam_set) begin
        lam_pend_r <= 1'b1;
      end else if (seq_reset || f_clear_lam) begin
        lam_pend_r <= 1'b0;
      end
      if (f_lam_on) begin
        lam_en_r <= 1'b1;
      end else if (f_lam_off) begin
        lam_en_r <= 1'b0;
      end
      lam_line_r <= lam_pend_r && lam_en_r;
    end
  end

  // Sample clock divider
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div_r <= 18'h00000;
    end else if (ext_selected || div_r <= 18'h00001) begin
      div_r <= rate_div(clk_sel);
    end else begin
      div_r <= div_r - 18'h00001;
    end
  end

  // Post-trigger counter
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      counting_r <= 1'b0;
      readout_r <= 1'b0;
      pt_count_r <= 16'h0000;
    end else if (seq_reset) begin
      counting_r <= 1'b0;
      readout_r <= 1'b0;
      pt_count_r <= preset;
    end else if (enter_readout) begin
      counting_r <= 1'b0;
      readout_r <= 1'b1;
      pt_count_r <= terminal;
    end else if (counting_r) begin
      if (gated_sample) begin
        pt_count_r <= 16'(pt_count_r + 16'h0001);
      end
    end else if (stop_evt) begin
      counting_r <= 1'b1;
      pt_count_r <= preset;
    end else if (!readout_r) begin
      pt_count_r <= preset;
    end
  end

  // Sampling, single scan and data validity
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sample_en_r <= 1'b1;
      scan_r <= acqs_pkg::ACQS_SCAN_IDLE;
      scan_timer_r <= 14'h0000;
      valid_r <= 1'b0;
      sample_strobe_r <= 1'b0;
      chan_rst_r <= 1'b0;
    end else begin
      sample_en_r <= sample_en_nxt;
      scan_r <= scan_nxt;
      if ((scan_r == acqs_pkg::ACQS_SCAN_ARMED) && gated_sample) begin
        scan_timer_r <= scan_wait;
      end else if (scan_timer_r != 14'h0000) begin
        scan_timer_r <= scan_timer_r - 14'h0001;
      end
      if (seq_reset) begin
        valid_r <= 1'b0;
      end else if (gated_sample) begin
        valid_r <= 1'b1;
      end
      sample_strobe_r <= gated_sample;
      chan_rst_r <= seq_reset || f_cont;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0;
  assign sample_strobe = sample_strobe_r;
  assign channel_counter_reset = chan_rst_r;
  assign readout_mode = readout_r;
  assign data_valid = valid_r;
  assign lam_line = lam_line_r;
  assign post_trigger_latch_bits = ptl;
endmodule

// ---- verification/acqs_properties.sv ----
`timescale 1ns/100ps
module acqs_properties (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic dataway_clear,
  input wire logic dataway_init,
  input wire logic sample_strobe,
  input wire logic channel_counter_reset,
  input wire logic readout_mode,
  input wire logic data_valid,
  input wire logic lam_line,
  input wire logic [2:0] post_trigger_latch_bits
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_clr;
    dataway_clear [*5] |=> !readout_mode && !lam_line;
  endproperty
  a_clr: assert property (p_clr) else $error("clear left readout or request set");
  property p_init;
    dataway_init [*5] |=> !readout_mode && !lam_line && !data_valid;
  endproperty
  a_init: assert property (p_init) else $error("init left state set");
  property p_ccr;
    (dataway_clear || dataway_init) [*5] |-> channel_counter_reset;
  endproperty
  a_ccr: assert property (p_ccr) else $error("no channel counter reset");
  property p_pulse;
    sample_strobe |=> !sample_strobe;
  endproperty
  a_pulse: assert property (p_pulse) else $error("sample strobe too long");
  property p_vset;
    sample_strobe |=> data_valid || channel_counter_reset;
  endproperty
  a_vset: assert property (p_vset) else $error("sample did not mark data valid");
  property p_vfall;
    $fell(data_valid) |-> channel_counter_reset || $past(channel_counter_reset);
  endproperty
  a_vfall: assert property (p_vfall) else $error("data invalidated without reset");
  property p_rofall;
    $fell(readout_mode) |-> channel_counter_reset || $past(channel_counter_reset);
  endproperty
  a_rofall: assert property (p_rofall) else $error("readout left without reset");
  property p_ro;
    readout_mode && $past(readout_mode) |-> !sample_strobe;
  endproperty
  a_ro: assert property (p_ro) else $error("sample during readout");
  property p_latch;
    (dataway_clear || dataway_init) && !$past(hsel) |=> $stable(post_trigger_latch_bits);
  endproperty
  a_latch: assert property (p_latch) else $error("reset changed latch");
endmodule

bind acqs_sequencer acqs_properties u_props (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel),
  .dataway_clear(dataway_clear), .dataway_init(dataway_init), .sample_strobe(sample_strobe),
  .channel_counter_reset(channel_counter_reset), .readout_mode(readout_mode),
  .data_valid(data_valid), .lam_line(lam_line),
  .post_trigger_latch_bits(post_trigger_latch_bits));

// ---- verification/acqs_ctl_model.sv ----
`timescale 1ns/100ps
module acqs_ctl_model (
  input wire logic ref_clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic dataway_clear,
  output logic dataway_init
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    dataway_clear = 1'b0;
    dataway_init = 1'b0;
  end

  // No latency assumed: both phases wait on hready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : ~hwdata;
    do @(posedge ref_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h00000000, q);
  endtask

  // Long enough to pass the input synchronisers
  task automatic crate_reset(input logic z);
    @(posedge ref_clk);
    dataway_init <= z;
    dataway_clear <= !z;
    repeat (8) @(posedge ref_clk);
    dataway_init <= 1'b0;
    dataway_clear <= 1'b0;
  endtask
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  logic ref_clk, rst_n, stop_trigger_in, external_sample_input;
  logic hsel, hwrite, hreadyout, hresp, dataway_clear, dataway_init;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, post_trigger_latch_bits;
  logic sample_strobe, channel_counter_reset, readout_mode, data_valid, lam_line;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int strobes = 0;
  int last_s = 0;
  int ccrs = 0;

  acqs_ctl_model ctl (.ref_clk(ref_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .dataway_clear(dataway_clear), .dataway_init(dataway_init));

  // Short first divisor keeps the slowest internal rate simulable
  acqs_sequencer #(.DIV_1(20)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .dataway_clear(dataway_clear),
    .dataway_init(dataway_init), .stop_trigger_in(stop_trigger_in),
    .external_sample_input(external_sample_input), .sample_strobe(sample_strobe),
    .channel_counter_reset(channel_counter_reset), .readout_mode(readout_mode),
    .data_valid(data_valid), .lam_line(lam_line),
    .post_trigger_latch_bits(post_trigger_latch_bits));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (sample_strobe === 1'b1) begin
      strobes++;
      last_s = cyc;
    end
    if (channel_counter_reset === 1'b1) ccrs++;
    if (cyc > 30000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h got %h", n, e, g);
    end
  endtask

  task automatic fn(input logic [4:0] f, input logic [7:0] wd);
    ctl.wr(acqs_pkg::ACQS_OFF_CMD, {16'h0000, wd, 3'h0, f});
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic pulse(input int n);
    repeat (n) fn(acqs_pkg::ACQS_F_BUS_CLOCK, 8'h00);
  endtask

  task automatic t_latch;
    logic [31:0] q;
    int s0;
    fn(acqs_pkg::ACQS_F_SET_LATCH, 8'hA6);
    ctl.rd(acqs_pkg::ACQS_OFF_LATCH, q);
    chk("latch", 8'hA6, q[7:0]);
    chk("latch bits", 3'h5, post_trigger_latch_bits);
    // Counted between falling edges, clear of the strobe counter's edge
    @(negedge ref_clk);
    s0 = strobes;
    repeat (200) @(negedge ref_clk);
    chk("internal rate", 32'(s0 + 10), 32'(strobes));
    ctl.wr(acqs_pkg::ACQS_OFF_JMP_LO, 32'h00000023);
    ctl.rd(acqs_pkg::ACQS_OFF_STATUS, q);
    chk("latch jumpers", 16'h0070, q[31:16]);
    ctl.crate_reset(1'b0);
    repeat (4) @(posedge ref_clk);
    fn(acqs_pkg::ACQS_F_READ_LATCH, 8'h00);
    ctl.rd(acqs_pkg::ACQS_OFF_RESP, q);
    chk("latch readback", 9'h1A6, q[8:0]);
    ctl.rd(8'h1C, q);
    chk("unmapped", 32'h00000000, q);
  endtask

  // Jumpers: bits 13..7 (14..7 when m is 2) tied high, 6..4 from latch bit 0, 3..0 low
  task automatic t_pts(input logic [1:0] m, input logic [31:0] jhi, input logic pin);
    logic [31:0] q;
    int s0;
    ctl.wr(acqs_pkg::ACQS_OFF_CONFIG, {30'h00000000, m});
    ctl.wr(acqs_pkg::ACQS_OFF_JMP_HI, jhi);
    ctl.wr(acqs_pkg::ACQS_OFF_JMP_LO, 32'h00000010);
    fn(acqs_pkg::ACQS_F_SET_LATCH, 8'h20);
    fn(acqs_pkg::ACQS_F_RESET, 8'h00);
    s0 = strobes;
    pulse(3);
    chk("pre samples", 32'(s0 + 3), 32'(strobes));
    chk("valid", 1'b1, data_valid);
    ctl.rd(acqs_pkg::ACQS_OFF_STATUS, q);
    chk("idle counter", 1'b0, q[4]);
    if (pin) begin
      stop_trigger_in <= 1'b1;
      repeat (6) @(posedge ref_clk);
      stop_trigger_in <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end else begin
      fn(acqs_pkg::ACQS_F_STOP, 8'h00);
    end
    ctl.rd(acqs_pkg::ACQS_OFF_STATUS, q);
    chk("counting", 1'b1, q[4]);
    chk("preset", 16'(m * acqs_pkg::ACQS_HALF_MODULE - 16'h0010), q[31:16]);
    pulse(8);
    fn(acqs_pkg::ACQS_F_STOP, 8'h00);
    pulse(7);
    chk("early readout", 1'b0, readout_mode);
    pulse(1);
    chk("readout", 1'b1, readout_mode);
    pulse(2);
    chk("samples", 32'(s0 + 19), 32'(strobes));
    fn(acqs_pkg::ACQS_F_TEST_LAM, 8'h00);
    ctl.rd(acqs_pkg::ACQS_OFF_RESP, q);
    chk("test request", 1'b1, q[9]);
    chk("line disabled", 1'b0, lam_line);
    fn(acqs_pkg::ACQS_F_LAM_ON, 8'h00);
    chk("line enabled", 1'b1, lam_line);
    fn(acqs_pkg::ACQS_F_RESET, 8'h00);
    ctl.rd(acqs_pkg::ACQS_OFF_RESP, q);
    chk("reset accepted", 1'b1, q[8]);
    chk("reset readout", 1'b0, readout_mode);
    chk("reset line", 1'b0, lam_line);
    chk("reset valid", 1'b0, data_valid);
    ctl.rd(acqs_pkg::ACQS_OFF_STATUS, q);
    chk("reset enables", 2'h3, q[2:1]);
    fn(acqs_pkg::ACQS_F_LAM_OFF, 8'h00);
  endtask

  task automatic t_single;
    logic [31:0] q;
    int s0;
    int c0;
    int d;
    int e;
    e = 4 * acqs_pkg::ACQS_SCAN_CYC_PER_CH;
    fn(acqs_pkg::ACQS_F_LAM_ON, 8'h00);
    fn(acqs_pkg::ACQS_F_SINGLE, 8'h00);
    s0 = strobes;
    pulse(2);
    chk("single scan", 32'(s0 + 1), 32'(strobes));
    d = 0;
    while (lam_line !== 1'b1 && d < 2000) begin
      @(posedge ref_clk);
      d++;
    end
    d = cyc - last_s;
    chk("request delay", 1'b1, d >= e - 2 && d <= e + 6);
    fn(acqs_pkg::ACQS_F_TEST_LAM, 8'h00);
    ctl.rd(acqs_pkg::ACQS_OFF_RESP, q);
    chk("single request", 1'b1, q[9]);
    fn(acqs_pkg::ACQS_F_CLEAR_LAM, 8'h00);
    chk("request cleared", 1'b0, lam_line);
    c0 = ccrs;
    fn(acqs_pkg::ACQS_F_CONTINUOUS, 8'h00);
    chk("channel reset", 1'b1, ccrs > c0);
    s0 = strobes;
    pulse(2);
    chk("continuous", 32'(s0 + 2), 32'(strobes));
    external_sample_input <= 1'b1;
    repeat (8) @(posedge ref_clk);
    pulse(1);
    chk("edge only", 32'(s0 + 3), 32'(strobes));
    external_sample_input <= 1'b0;
    ctl.crate_reset(1'b1);
    repeat (4) @(posedge ref_clk);
    chk("init valid", 1'b0, data_valid);
    chk("response", 1'b0, hresp);
  endtask

  initial begin
    rst_n = 1'b0;
    stop_trigger_in = 1'b0;
    external_sample_input = 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_latch();
    t_pts(2'h1, 32'h01249240, 1'b0);
    t_pts(2'h2, 32'h01249248, 1'b1);
    t_single();
    report_and_stop();
  end
endmodule
